// >>> cowd_pkg.sv
// package for the clock option word decoder: field positions, reset values, types
// assumes a single synchronous clock domain and 13-bit option words
package cowd_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 13;
  localparam int unsigned W0_RSVD_HI = 12;
  localparam int unsigned W0_RSVD_LO = 10;
  localparam int unsigned W0_PKG_BIT = 9;
  localparam int unsigned W0_IPER_BIT = 8;
  localparam int unsigned W0_WDT_BIT = 7;
  localparam int unsigned W0_OSC_HI = 6;
  localparam int unsigned W0_OSC_LO = 4;
  localparam int unsigned W0_PWR_BIT = 3;
  localparam int unsigned W0_PROT_HI = 2;
  localparam int unsigned W0_PROT_LO = 0;
  localparam int unsigned W1_RCF_HI = 1;
  localparam int unsigned W1_RCF_LO = 0;

  // ------------------------------------------------------------
  // reset values (erased / default state)
  // ------------------------------------------------------------
  localparam logic [12:0] WORD0_RST = 13'h1FFF;
  localparam logic [12:0] WORD1_RST = 13'h1FFF;
  localparam logic [12:0] WORD2_RST = 13'h1FFF;
  localparam logic [2:0] RSVD_ONES = 3'h7;
  localparam logic [1:0] OSC_MODE_RST = 2'h3;
  localparam logic [1:0] RCF_RST = 2'h3;

  // oscillator mode pattern codes
  localparam logic [2:0] OSC_ERC_PORT = 3'h0;
  localparam logic [2:0] OSC_ERC_OUT = 3'h1;
  localparam logic [2:0] OSC_IRC_PORT = 3'h2;
  localparam logic [2:0] OSC_IRC_OUT = 3'h3;
  localparam logic [2:0] OSC_LXT = 3'h6;
  localparam logic [2:0] OSC_HXT = 3'h7;

  // instruction cycle lengths in oscillator periods
  localparam logic [2:0] IPER_SHORT = 3'h2;
  localparam logic [2:0] IPER_LONG = 3'h4;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    COWD_SRC_EXT_RC,
    COWD_SRC_INT_RC,
    COWD_SRC_LF_XTAL,
    COWD_SRC_HF_XTAL
  } cowd_src_t;

  typedef enum logic [1:0] {
    COWD_RC_455K,
    COWD_RC_1M,
    COWD_RC_8M,
    COWD_RC_4M
  } cowd_rcf_t;

  typedef struct packed {
    logic [12:0] word0;
    logic [12:0] word1;
    logic [12:0] word2;
  } cowd_words_t;

  typedef struct packed {
    cowd_src_t src;
    logic osc_out_en;
    logic ext_clk_ok;
    logic bad_pattern;
    cowd_rcf_t rcf;
  } cowd_clk_cfg_t;

  typedef struct packed {
    logic small_pkg;
    logic [2:0] instr_periods;
    logic watchdog_en;
    logic high_power;
    logic [2:0] protect_en;
  } cowd_glob_cfg_t;

endpackage

// >>> cowd_osc_decode.sv
// oscillator mode and internal rc frequency decode, purely combinational
// assumes the option words feeding it are already stable captured values
`timescale 1ns/10ps
`default_nettype none
module cowd_osc_decode
  import cowd_pkg::*;
(
  input wire logic [2:0] clock_source_sel_i,
  input wire logic [1:0] int_rc_freq_sel_i,
  output cowd_pkg::cowd_clk_cfg_t clk_cfg_o
);

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  wire logic external_rc_mode;
  wire logic internal_rc_mode;
  wire logic low_freq_crystal_mode;
  wire logic high_freq_crystal_mode;
  wire logic undefined_mode;

  assign external_rc_mode = (clock_source_sel_i == OSC_ERC_PORT)
                          || (clock_source_sel_i == OSC_ERC_OUT);
  assign internal_rc_mode = (clock_source_sel_i == OSC_IRC_PORT)
                          || (clock_source_sel_i == OSC_IRC_OUT);
  assign low_freq_crystal_mode = (clock_source_sel_i == OSC_LXT);
  // unlisted patterns fall back to the default crystal mode
  assign undefined_mode = !(external_rc_mode || internal_rc_mode
                          || low_freq_crystal_mode
                          || (clock_source_sel_i == OSC_HXT));
  assign high_freq_crystal_mode = (clock_source_sel_i == OSC_HXT) || undefined_mode;

  assign clk_cfg_o.src = external_rc_mode ? COWD_SRC_EXT_RC :
                         internal_rc_mode ? COWD_SRC_INT_RC :
                         low_freq_crystal_mode ? COWD_SRC_LF_XTAL :
                         COWD_SRC_HF_XTAL;
  // crystal modes always own both pins; rc modes use the low select bit
  assign clk_cfg_o.osc_out_en = (external_rc_mode || internal_rc_mode)
                              ? clock_source_sel_i[0] : 1'b1;
  // an external clock drives the input pin in any mode but internal rc
  assign clk_cfg_o.ext_clk_ok = !internal_rc_mode;
  assign clk_cfg_o.bad_pattern = undefined_mode;
  assign clk_cfg_o.rcf = cowd_rcf_t'(int_rc_freq_sel_i);

endmodule
`default_nettype wire

// >>> cowd_top.sv
// clock option word decoder: captures the two option words and the id word after reset release
// assumes option bits are static fuse levels from outside the clock domain
//
// Operation
// - two 13-bit option words and one 13-bit id word, kept apart from code
// - word0 bits 12 to 10 always read as one
// - word0 bit 9: 0 larger package, 1 smaller packages, default 1
// - word0 bit 8: 0 two periods per instruction, 1 four, default 1
// - word0 bit 7 active low watchdog enable, default disabled
// - word0 bits 6..4 pick external rc, internal rc, lf or hf crystal
// - in rc modes bit 4 picks port bit or oscillator output
// - word0 bit 3: 0 low power up to 4 MHz, 1 high power above
// - word0 bits 2..0: 0 enables readout protection, 1 disables it
// - internal rc defaults to 4 MHz, also 1 MHz, 8 MHz, 455kHz
// - rc select 11 4 MHz, 10 8 MHz, 01 1 MHz, 00 455kHz
// - oscillator input pin accepts an external clock signal in all but the internal rc modes
`timescale 1ns/10ps
`default_nettype none
module cowd_top
  import cowd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [12:0] opt_word0_i,
  input wire logic [12:0] opt_word1_i,
  input wire logic [12:0] cust_id_i,
  output logic cfg_valid_o,
  output logic [12:0] word0_o,
  output logic [12:0] word1_o,
  output logic [12:0] cust_id_o,
  output logic small_pkg_o,
  output logic instr_period_select_o,
  output logic [2:0] instr_periods_o,
  output logic watchdog_enable_n_o,
  output logic watchdog_en_o,
  output logic [2:0] clock_source_sel_o,
  output cowd_pkg::cowd_src_t clk_src_o,
  output logic clock_output_pin_en_o,
  output logic port5_bit4_en_o,
  output logic ext_clk_ok_o,
  output logic bad_osc_pattern_o,
  output logic power_class_select_o,
  output logic [2:0] protect_en_o,
  output logic code_protect_o,
  output logic [1:0] int_rc_freq_sel_o,
  output cowd_pkg::cowd_rcf_t int_rc_freq_o
);

  // ------------------------------------------------------------
  // input synchronisers, two stages each
  // ------------------------------------------------------------
  cowd_words_t meta_ff;
  cowd_words_t sync_ff;
  cowd_words_t nxt_sync;
  cowd_words_t pin_words;

  assign pin_words = '{word0: opt_word0_i, word1: opt_word1_i, word2: cust_id_i};
  assign nxt_sync = meta_ff;

  always_ff @(posedge clk_sys_i)
  begin
    meta_ff <= pin_words;
    sync_ff <= nxt_sync;
  end

  // ------------------------------------------------------------
  // power-up capture
  // ------------------------------------------------------------
  // capture waits for the synchroniser to fill after release so no
  // metastable or pre-reset value is ever latched
  typedef enum logic [1:0] {
    CAP_RESET,
    CAP_FILL,
    CAP_TAKE,
    CAP_HOLD
  } cowd_cap_t;

  cowd_cap_t state_ff;
  cowd_cap_t nxt_state;
  cowd_words_t words_ff;
  cowd_words_t nxt_words;
  logic valid_ff;
  logic nxt_valid;
  wire logic take_now;

  assign take_now = (state_ff == CAP_TAKE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CAP_RESET: nxt_state = CAP_FILL;
      CAP_FILL: nxt_state = CAP_TAKE;
      CAP_TAKE: nxt_state = CAP_HOLD;
      CAP_HOLD: nxt_state = CAP_HOLD;
      default: nxt_state = CAP_RESET;
    endcase
  end

  // reserved bits of word0 forced to one regardless of the fuse state
  assign nxt_words = take_now
    ? '{word0: {RSVD_ONES, sync_ff.word0[W0_PKG_BIT:0]},
        word1: sync_ff.word1,
        word2: sync_ff.word2}
    : words_ff;
  assign nxt_valid = valid_ff || take_now;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= CAP_RESET;
      words_ff <= '{word0: WORD0_RST, word1: WORD1_RST, word2: WORD2_RST};
      valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      words_ff <= nxt_words;
      valid_ff <= nxt_valid;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  cowd_clk_cfg_t clk_cfg;
  cowd_glob_cfg_t glob_cfg;
  wire logic [12:0] w0;

  assign w0 = words_ff.word0;

  cowd_osc_decode u_osc_decode (
    .clock_source_sel_i(w0[W0_OSC_HI:W0_OSC_LO]),
    .int_rc_freq_sel_i(words_ff.word1[W1_RCF_HI:W1_RCF_LO]),
    .clk_cfg_o(clk_cfg)
  );

  assign glob_cfg.small_pkg = w0[W0_PKG_BIT];
  assign glob_cfg.instr_periods = w0[W0_IPER_BIT] ? IPER_LONG : IPER_SHORT;
  assign glob_cfg.watchdog_en = !w0[W0_WDT_BIT];
  // bit only records the class; frequency range check is the integrator's job
  assign glob_cfg.high_power = w0[W0_PWR_BIT];
  assign glob_cfg.protect_en = ~w0[W0_PROT_HI:W0_PROT_LO];

  // ------------------------------------------------------------
  // outputs, all from the held capture register
  // ------------------------------------------------------------
  assign cfg_valid_o = valid_ff;
  assign word0_o = w0;
  assign word1_o = words_ff.word1;
  assign cust_id_o = words_ff.word2;
  assign small_pkg_o = glob_cfg.small_pkg;
  assign instr_period_select_o = w0[W0_IPER_BIT];
  assign instr_periods_o = glob_cfg.instr_periods;
  assign watchdog_enable_n_o = w0[W0_WDT_BIT];
  assign watchdog_en_o = glob_cfg.watchdog_en;
  assign clock_source_sel_o = w0[W0_OSC_HI:W0_OSC_LO];
  assign clk_src_o = clk_cfg.src;
  assign clock_output_pin_en_o = clk_cfg.osc_out_en;
  assign port5_bit4_en_o = !clk_cfg.osc_out_en;
  assign ext_clk_ok_o = clk_cfg.ext_clk_ok;
  assign bad_osc_pattern_o = clk_cfg.bad_pattern;
  assign power_class_select_o = glob_cfg.high_power;
  assign protect_en_o = glob_cfg.protect_en;
  // any enabled protect bit locks readout
  assign code_protect_o = |glob_cfg.protect_en;
  assign int_rc_freq_sel_o = words_ff.word1[W1_RCF_HI:W1_RCF_LO];
  assign int_rc_freq_o = clk_cfg.rcf;

endmodule
`default_nettype wire

// >>> cowd_top_properties.sv
// port assertions for the clock option word decoder
// assumes fuse inputs stay static around each capture
`timescale 1ns/10ps
`default_nettype none
module cowd_top_properties
  import cowd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [12:0] opt_word0_i,
  input wire logic cfg_valid_o,
  input wire logic [12:0] word0_o,
  input wire logic [12:0] word1_o,
  input wire logic small_pkg_o,
  input wire logic [2:0] instr_periods_o,
  input wire logic watchdog_en_o,
  input wire logic [1:0] clk_src_o,
  input wire logic clock_output_pin_en_o,
  input wire logic power_class_select_o,
  input wire logic [2:0] protect_en_o,
  input wire logic [1:0] int_rc_freq_o
);
  import cowd_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ------------------------------------------------------------
  // capture sequence
  // ------------------------------------------------------------
  sequence s_fill;
    !cfg_valid_o [*3];
  endsequence
  // the held word is the pin level seen at the release edge, two stages late
  sequence s_live;
    cfg_valid_o && word0_o[9:0] == $past(opt_word0_i[9:0], 3);
  endsequence
  sequence s_held;
    cfg_valid_o && $stable(word0_o) && $stable(word1_o);
  endsequence
  sequence s_rc_src;
    clk_src_o == (word0_o[5] ? COWD_SRC_INT_RC : COWD_SRC_EXT_RC);
  endsequence
  sequence s_xtal_src;
    clk_src_o == (word0_o[4] ? COWD_SRC_HF_XTAL : COWD_SRC_LF_XTAL);
  endsequence
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_capture_time: assert property ($rose(rst_b_i) |-> s_fill ##1 s_live)
    else $error("capture not at third edge after release");
  a_hold_cfg: assert property (cfg_valid_o |=> s_held)
    else $error("captured words moved");
  a_rsvd_ones: assert property (cfg_valid_o |-> word0_o[12:10] == 3'h7)
    else $error("reserved bits not one");
  a_pkg_bit: assert property (small_pkg_o == word0_o[9])
    else $error("package bit wrong");
  a_instr_period: assert property (instr_periods_o == (word0_o[8] ? 3'h4 : 3'h2))
    else $error("instruction period wrong");
  a_wdt_low: assert property (watchdog_en_o != word0_o[7])
    else $error("watchdog polarity wrong");
  a_src_rc: assert property (!word0_o[6] |-> s_rc_src)
    else $error("rc source wrong");
  a_src_xtal: assert property (word0_o[6:5] == 2'h3 |-> s_xtal_src)
    else $error("crystal source wrong");
  a_pin_role: assert property (!word0_o[6] |-> clock_output_pin_en_o == word0_o[4])
    else $error("pin role wrong");
  a_power_bit: assert property (power_class_select_o == word0_o[3])
    else $error("power class wrong");
  a_prot_low: assert property (protect_en_o == ~word0_o[2:0])
    else $error("protection polarity wrong");
  a_rc_freq: assert property (int_rc_freq_o == word1_o[1:0])
    else $error("rc frequency wrong");
endmodule
bind cowd_top cowd_top_properties u_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .opt_word0_i(opt_word0_i), .cfg_valid_o(cfg_valid_o), .word0_o(word0_o), .word1_o(word1_o),
  .small_pkg_o(small_pkg_o), .instr_periods_o(instr_periods_o), .watchdog_en_o(watchdog_en_o),
  .clk_src_o(clk_src_o), .clock_output_pin_en_o(clock_output_pin_en_o),
  .power_class_select_o(power_class_select_o), .protect_en_o(protect_en_o),
  .int_rc_freq_o(int_rc_freq_o));
`default_nettype wire

// >>> tb.sv
// self-checking bench for the clock option word decoder
// assumes capture on the third edge after reset release
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cowd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [12:0] opt_word0_i = 13'h1FFF;
  logic [12:0] opt_word1_i = 13'h1FFF;
  logic [12:0] cust_id_i = 13'h0000;
  logic cfg_valid_o, small_pkg_o, instr_period_select_o, watchdog_enable_n_o, watchdog_en_o;
  logic clock_output_pin_en_o, port5_bit4_en_o, ext_clk_ok_o, bad_osc_pattern_o;
  logic power_class_select_o, code_protect_o;
  logic [12:0] word0_o, word1_o, cust_id_o;
  logic [2:0] instr_periods_o, clock_source_sel_o, protect_en_o;
  logic [1:0] int_rc_freq_sel_o;
  cowd_src_t clk_src_o;
  cowd_rcf_t int_rc_freq_o;
  int fails = 0;
  int check_count = 0;
  cowd_top DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .opt_word0_i(opt_word0_i),
    .opt_word1_i(opt_word1_i), .cust_id_i(cust_id_i), .cfg_valid_o(cfg_valid_o),
    .word0_o(word0_o), .word1_o(word1_o), .cust_id_o(cust_id_o), .small_pkg_o(small_pkg_o),
    .instr_period_select_o(instr_period_select_o), .instr_periods_o(instr_periods_o),
    .watchdog_enable_n_o(watchdog_enable_n_o), .watchdog_en_o(watchdog_en_o),
    .clock_source_sel_o(clock_source_sel_o), .clk_src_o(clk_src_o),
    .clock_output_pin_en_o(clock_output_pin_en_o), .port5_bit4_en_o(port5_bit4_en_o),
    .ext_clk_ok_o(ext_clk_ok_o), .bad_osc_pattern_o(bad_osc_pattern_o),
    .power_class_select_o(power_class_select_o), .protect_en_o(protect_en_o),
    .code_protect_o(code_protect_o), .int_rc_freq_sel_o(int_rc_freq_sel_o),
    .int_rc_freq_o(int_rc_freq_o));
  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // fuses set while reset is low so the synchroniser is full at release
  task automatic run_case(input logic [12:0] w0, input logic [12:0] w1, input logic [12:0] id);
    logic [2:0] osc;
    logic pin;
    logic [1:0] src;
    osc = w0[6:4];
    pin = osc[2] | osc[0];
    // unlisted 100 and 101 fall back to the default crystal
    src = osc[2] ? (osc[1] ? {1'b1, osc[0]} : 2'h3) : {1'b0, osc[1]};
    @(posedge clk_sys_i) #10;
    rst_b_i = 1'b0;
    opt_word0_i = w0;
    opt_word1_i = w1;
    cust_id_i = id;
    repeat (2) @(posedge clk_sys_i);
    #10 rst_b_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #10;
    chk("early valid", 13'(cfg_valid_o), 13'h0000);
    @(posedge clk_sys_i) #10;
    chk("valid", 13'(cfg_valid_o), 13'h0001);
    chk("word0", word0_o, {3'h7, w0[9:0]});
    chk("word1", word1_o, w1);
    chk("id", cust_id_o, id);
    chk("pkg", 13'(small_pkg_o), 13'(w0[9]));
    chk("iper", 13'(instr_periods_o), w0[8] ? 13'h0004 : 13'h0002);
    chk("iper sel", 13'(instr_period_select_o), 13'(w0[8]));
    chk("wdt", 13'({watchdog_en_o, watchdog_enable_n_o}), 13'({~w0[7], w0[7]}));
    chk("osc sel", 13'(clock_source_sel_o), 13'(osc));
    chk("src", 13'(clk_src_o), 13'(src));
    chk("bad osc", 13'(bad_osc_pattern_o), 13'(osc[2] & ~osc[1]));
    chk("pin", 13'({clock_output_pin_en_o, port5_bit4_en_o}), 13'({pin, ~pin}));
    chk("extclk", 13'(ext_clk_ok_o), 13'(osc[2:1] != 2'h1));
    chk("power", 13'(power_class_select_o), 13'(w0[3]));
    chk("prot", 13'({code_protect_o, protect_en_o}), 13'({|(~w0[2:0]), ~w0[2:0]}));
    chk("rcf", 13'(int_rc_freq_o), 13'(w1[1:0]));
    chk("rcf sel", 13'(int_rc_freq_sel_o), 13'(w1[1:0]));
    opt_word0_i = ~w0;
    opt_word1_i = ~w1;
    cust_id_i = ~id;
    repeat (4) @(posedge clk_sys_i);
    #10;
    chk("hold w0", word0_o, {3'h7, w0[9:0]});
    chk("hold w1", word1_o, w1);
    chk("hold id", cust_id_o, id);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  // 110 stands for a clock below the crystal split, 111 at or above it
  logic [2:0] oscs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #10;
    chk("rst valid", 13'(cfg_valid_o), 13'h0000);
    chk("rst word0", word0_o, 13'h1FFF);
    chk("rst src", 13'(clk_src_o), 13'(COWD_SRC_HF_XTAL));
    chk("rst rcf", 13'(int_rc_freq_o), 13'(COWD_RC_4M));
    for (int i = 0; i < 8; i++)
      run_case({3'h0, i[0], ~i[0], i[1], oscs[i], i[0], 3'(i)}, {11'(i * 5), i[1:0]},
        13'(i * 291));
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys_i);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
